/* File: core/uefa_fifo.sv */
// One endpoint FIFO: flip-flop storage with push, pop and clear.
// Ignores a push when full and a pop when empty.
`timescale 1ns/1ns
module uefa_fifo
    import uefa_pkg::*;
#(
    parameter int W     = DATA_W,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1)
)
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // Control
    input  wire logic          clr,
    input  wire logic          push,
    input  wire logic [W-1:0]  push_data,
    input  wire logic          pop,
    // State
    output logic      [W-1:0]  head,
    output logic      [CW-1:0] count,
    output logic               full,
    output logic               empty
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] cnt_r;
    logic          do_push;
    logic          do_pop;

    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign head    = mem_r[rd_ptr_r];
    assign count   = cnt_r;
    assign full    = (cnt_r == CW'(DEPTH));
    assign empty   = (cnt_r == '0);

    always_ff @(posedge clk)
    begin
        if (do_push)
        begin
            mem_r[wr_ptr_r] <= push_data;
        end
    end

    // Clear wins over any access in the same cycle.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end
        else if (clr)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
            if (do_pop)
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
            cnt_r <= cnt_r + CW'(do_push) - CW'(do_pop);
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (reset)
        cnt_r <= CW'(DEPTH))
        else $error("fifo count above depth");

    a_fifo_clear: assert property (@(posedge clk) disable iff (reset)
        clr |=> empty)
        else $error("fifo not empty after clear");

endmodule

/* File: core/uefa_pkg.sv */
// Shared constants for the endpoint FIFO access block: register offsets,
// command/status field positions, reset values and FIFO geometry.
// Assumes a plain byte-wide register port on the processor side.
package uefa_pkg;

    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int NUM_PIPES  = 2;
    localparam int ADDR_W     = 8;
    localparam int CNT_W      = $clog2(FIFO_DEPTH + 1);

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CMD      = 8'h46;
    localparam logic [ADDR_W-1:0] OFF_DP0      = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_DP1      = 8'h49;
    localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h4A;
    localparam logic [ADDR_W-1:0] OFF_INT_CLR  = 8'h4B;
    localparam logic [ADDR_W-1:0] OFF_INT_EN   = 8'h4C;
    localparam logic [ADDR_W-1:0] OFF_SVC_PIPE = 8'h4D;

    // ---------------------------------------------------------------
    // Command/status field positions
    // ---------------------------------------------------------------
    localparam int B_REQ    = 0;
    localparam int B_TX     = 1;
    localparam int B_CLR    = 2;
    localparam int B_SEL_LO = 3;
    localparam int B_SEL_HI = 4;
    localparam int B_SETUP  = 5;
    localparam int B_READY  = 6;
    localparam int B_ZERO   = 7;

    // ---------------------------------------------------------------
    // Encodings and reset values
    // ---------------------------------------------------------------
    localparam logic [1:0]          PIPE_SELECT_LOW  = 2'h0;
    localparam logic [1:0]          PIPE_SELECT_HIGH  = 2'h1;
    localparam logic [DATA_W-1:0]   BYTE_ZERO  = 8'h00;
    localparam logic [NUM_PIPES-1:0] INT_RST   = 2'h0;
    localparam logic [CNT_W-1:0]    CNT_ZERO   = 4'h0;

endpackage

/* File: core/uefa_top.sv */
// Processor-side access logic for two endpoint FIFOs shared with the
// USB serial engine, with command/status register and pipe interrupt.
// Assumes a plain register port and an engine that holds eng_busy for
// the pipe it is using and only pushes or pops on that pipe.
`timescale 1ns/1ns
module uefa_top
    import uefa_pkg::*;
#(
    parameter int DW    = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // Register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DW-1:0]        reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DW-1:0]        reg_rdata,
    // Engine receive side (OUT and SETUP data into the FIFOs)
    input  wire logic                 eng_push,
    input  wire logic                 eng_push_pipe,
    input  wire logic [DW-1:0]        eng_push_data,
    input  wire logic                 eng_pkt_end,
    input  wire logic                 eng_pkt_pipe,
    input  wire logic                 eng_pkt_setup,
    input  wire logic                 eng_pkt_zero,
    input  wire logic                 eng_setup_token,
    // Engine transmit side (IN data out of the FIFOs)
    input  wire logic                 eng_pop,
    input  wire logic                 eng_pop_pipe,
    output logic      [DW-1:0]        eng_pop_data,
    output logic                      eng_tx_ready,
    output logic                      eng_tx_pipe,
    output logic      [CNT_W-1:0]     eng_tx_len,
    output logic                      eng_rx_release,
    output logic                      eng_rx_pipe,
    // Engine pipe ownership
    input  wire logic [NUM_PIPES-1:0] eng_busy,
    input  wire logic                 eng_done,
    input  wire logic                 eng_done_pipe,
    // Interrupt
    output logic                      irq
);

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic                 req_r;
    logic                 tx_r;
    logic [1:0]           sel_r;
    logic                 setup_r;
    logic                 zero_r;
    logic                 zero_pipe_r;
    logic [NUM_PIPES-1:0] stat_r;
    logic [NUM_PIPES-1:0] en_r;
    logic                 svc_pipe_r;
    logic                 irq_r;
    logic [DW-1:0]        rd_data_r;
    logic [DW-1:0]        pop_data_r;
    logic                 tx_ready_r;
    logic                 tx_pipe_r;
    logic [CNT_W-1:0]     tx_len_r;
    logic                 rx_rel_r;
    logic                 rx_pipe_r;

    // ---------------------------------------------------------------
    // FIFO wiring
    // ---------------------------------------------------------------
    logic [DW-1:0]        fifo_head  [NUM_PIPES];
    logic [CNT_W-1:0]     fifo_cnt   [NUM_PIPES];
    logic [DW-1:0]        fifo_wdata [NUM_PIPES];
    logic [NUM_PIPES-1:0] fifo_full;
    logic [NUM_PIPES-1:0] fifo_empty;
    logic [NUM_PIPES-1:0] fifo_push;
    logic [NUM_PIPES-1:0] fifo_pop;
    logic [NUM_PIPES-1:0] fifo_clr;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    wire wr_cmd  = reg_wr && (reg_addr == OFF_CMD);
    wire wr_iclr = reg_wr && (reg_addr == OFF_INT_CLR);
    wire wr_ien  = reg_wr && (reg_addr == OFF_INT_EN);
    wire dp_hit  = (reg_addr == OFF_DP0) || (reg_addr == OFF_DP1);
    wire dp_pipe = (reg_addr == OFF_DP1);

    // ---------------------------------------------------------------
    // Pipe selection and readiness
    // ---------------------------------------------------------------
    wire sel_ok    = (sel_r == PIPE_SELECT_LOW) || (sel_r == PIPE_SELECT_HIGH);
    wire sel_idx   = (sel_r == PIPE_SELECT_HIGH);
    wire pipe_free = !eng_busy[sel_idx];
    wire claim     = req_r && sel_ok && pipe_free;
    wire rd_ok     = claim && !tx_r && !fifo_empty[sel_idx];
    wire wr_ok     = claim && tx_r && !fifo_full[sel_idx];
    wire ready     = rd_ok || wr_ok;
    wire dp_match  = (dp_pipe == sel_idx);

    // Data port transfers.
    wire mcu_rd_pop  = reg_rd && dp_hit && dp_match && rd_ok;
    wire mcu_wr_push = reg_wr && dp_hit && dp_match && wr_ok;

    // Direction changes while requesting mark the end of a transfer.
    wire tx_end = wr_cmd && claim && tx_r && !reg_wdata[B_TX];
    wire rx_end = wr_cmd && claim && !tx_r && reg_wdata[B_TX];
    wire mcu_clr = wr_cmd && reg_wdata[B_CLR] && !reg_wdata[B_SEL_HI];
    wire clr_idx = reg_wdata[B_SEL_LO];

    // ---------------------------------------------------------------
    // FIFO instances
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PIPES; g++)
        begin : gen_pipe
            wire eng_push_g = eng_push && (eng_push_pipe == g);
            wire mcu_sel_g  = (sel_idx == g);

            assign fifo_push[g]  = eng_push_g || (mcu_wr_push && mcu_sel_g);
            assign fifo_wdata[g] = eng_push_g ? eng_push_data : reg_wdata;
            assign fifo_pop[g]   = (eng_pop && (eng_pop_pipe == g)) ||
                                   (mcu_rd_pop && mcu_sel_g);
            assign fifo_clr[g]   = mcu_clr && (clr_idx == g);

            uefa_fifo #(
                .W     (DW),
                .DEPTH (DEPTH),
                .CW    (CNT_W)
            ) u_fifo (
                .clk       (ref_clk),
                .reset     (reset),
                .clr       (fifo_clr[g]),
                .push      (fifo_push[g]),
                .push_data (fifo_wdata[g]),
                .pop       (fifo_pop[g]),
                .head      (fifo_head[g]),
                .count     (fifo_cnt[g]),
                .full      (fifo_full[g]),
                .empty     (fifo_empty[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Sticky flags
    // ---------------------------------------------------------------
    wire setup_set = eng_pkt_end && eng_pkt_setup;
    wire setup_clr = wr_cmd && !reg_wdata[B_SETUP];
    wire setup_nxt = setup_set || (setup_r && !setup_clr);

    wire zero_set  = eng_pkt_end && eng_pkt_zero;
    wire zero_rdc  = reg_rd && dp_hit && (dp_pipe == zero_pipe_r);
    wire zero_clr  = eng_setup_token || zero_rdc ||
                     (wr_cmd && !reg_wdata[B_ZERO]);
    wire zero_nxt  = zero_set || (zero_r && !zero_clr);

    // ---------------------------------------------------------------
    // Interrupt status
    // ---------------------------------------------------------------
    wire [NUM_PIPES-1:0] done_set =
        eng_done ? (NUM_PIPES'(1) << eng_done_pipe) : INT_RST;
    wire [NUM_PIPES-1:0] stat_clr =
        wr_iclr ? reg_wdata[NUM_PIPES-1:0] : INT_RST;
    wire [NUM_PIPES-1:0] stat_nxt = (stat_r & ~stat_clr) | done_set;
    wire [NUM_PIPES-1:0] en_nxt   =
        wr_ien ? reg_wdata[NUM_PIPES-1:0] : en_r;

    // ---------------------------------------------------------------
    // Read data selection
    // ---------------------------------------------------------------
    logic [DW-1:0] cmd_view;

    always_comb
    begin
        cmd_view           = BYTE_ZERO;
        cmd_view[B_REQ]    = req_r;
        cmd_view[B_TX]     = tx_r;
        cmd_view[B_SEL_LO] = sel_r[0];
        cmd_view[B_SEL_HI] = sel_r[1];
        cmd_view[B_SETUP]  = setup_r;
        cmd_view[B_READY]  = ready;
        cmd_view[B_ZERO]   = zero_r;
    end

    wire [DW-1:0] dp_view  = mcu_rd_pop ? fifo_head[sel_idx] : BYTE_ZERO;
    wire [DW-1:0] rd_mux   =
        (reg_addr == OFF_CMD)      ? cmd_view :
        dp_hit                     ? dp_view :
        (reg_addr == OFF_INT_STAT) ? DW'(stat_r) :
        (reg_addr == OFF_INT_EN)   ? DW'(en_r) :
        (reg_addr == OFF_SVC_PIPE) ? DW'(svc_pipe_r) :
                                     BYTE_ZERO;

    // ---------------------------------------------------------------
    // Command register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            req_r <= 1'b0;
            tx_r  <= 1'b0;
            sel_r <= PIPE_SELECT_LOW;
        end
        else if (wr_cmd)
        begin
            req_r <= reg_wdata[B_REQ];
            tx_r  <= reg_wdata[B_TX];
            sel_r <= {reg_wdata[B_SEL_HI], reg_wdata[B_SEL_LO]};
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            setup_r     <= 1'b0;
            zero_r      <= 1'b0;
            zero_pipe_r <= 1'b0;
        end
        else
        begin
            setup_r <= setup_nxt;
            zero_r  <= zero_nxt;
            if (zero_set)
                zero_pipe_r <= eng_pkt_pipe;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            stat_r     <= INT_RST;
            en_r       <= INT_RST;
            svc_pipe_r <= 1'b0;
            irq_r      <= 1'b0;
        end
        else
        begin
            stat_r <= stat_nxt;
            en_r   <= en_nxt;
            irq_r  <= |(stat_nxt & en_nxt);
            if (eng_done)
                svc_pipe_r <= eng_done_pipe;
        end
    end

    // ---------------------------------------------------------------
    // Read data and engine hand-off
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rd_data_r  <= BYTE_ZERO;
            pop_data_r <= BYTE_ZERO;
            tx_ready_r <= 1'b0;
            tx_pipe_r  <= 1'b0;
            tx_len_r   <= CNT_ZERO;
            rx_rel_r   <= 1'b0;
            rx_pipe_r  <= 1'b0;
        end
        else
        begin
            rd_data_r  <= reg_rd ? rd_mux : BYTE_ZERO;
            tx_ready_r <= tx_end;
            rx_rel_r   <= rx_end;
            if (eng_pop)
                pop_data_r <= fifo_head[eng_pop_pipe];
            if (tx_end)
            begin
                tx_pipe_r <= sel_idx;
                tx_len_r  <= fifo_cnt[sel_idx];
            end
            if (rx_end)
                rx_pipe_r <= sel_idx;
        end
    end

    assign reg_rdata      = rd_data_r;
    assign eng_pop_data   = pop_data_r;
    assign eng_tx_ready   = tx_ready_r;
    assign eng_tx_pipe    = tx_pipe_r;
    assign eng_tx_len     = tx_len_r;
    assign eng_rx_release = rx_rel_r;
    assign eng_rx_pipe    = rx_pipe_r;
    assign irq            = irq_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence s_write_claimed;
        req_r && tx_r && claim && (fifo_cnt[sel_idx] == CNT_ZERO);
    endsequence

    sequence s_dir_drop;
        wr_cmd && reg_wdata[B_REQ] && !reg_wdata[B_TX];
    endsequence

    a_req_claim: assert property (@(posedge ref_clk) disable iff (reset)
        !req_r |-> !ready)
        else $error("ready without request");

    a_clear_empties: assert property (@(posedge ref_clk) disable iff (reset)
        mcu_clr |=> fifo_cnt[$past(clr_idx)] == CNT_ZERO)
        else $error("selected fifo not cleared");

    a_sel_invalid: assert property (@(posedge ref_clk) disable iff (reset)
        sel_r[1] |-> !ready)
        else $error("ready with unmapped pipe select");

    a_setup_set: assert property (@(posedge ref_clk) disable iff (reset)
        setup_set |=> setup_r && cmd_view[B_SETUP])
        else $error("setup flag not set");

    a_setup_hold: assert property (@(posedge ref_clk) disable iff (reset)
        setup_r && !setup_clr |=> setup_r)
        else $error("setup flag lost without firmware clear");

    a_zero_token: assert property (@(posedge ref_clk) disable iff (reset)
        eng_setup_token && !zero_set |=> !zero_r)
        else $error("zero flag survived setup token");

    a_ready_full: assert property (@(posedge ref_clk) disable iff (reset)
        tx_r && fifo_full[sel_idx] |-> !cmd_view[B_READY])
        else $error("ready while fifo full");

    a_zero_len_pkt: assert property (@(posedge ref_clk) disable iff (reset)
        s_write_claimed ##0 s_dir_drop |=>
            tx_ready_r && (tx_len_r == CNT_ZERO) ##1 !tx_ready_r)
        else $error("zero-length packet not handed off");

    a_busy_block: assert property (@(posedge ref_clk) disable iff (reset)
        eng_busy[sel_idx] |-> !ready)
        else $error("ready on pipe owned by engine");

    a_probe_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        wr_cmd && tx_r && reg_wdata[B_TX] |=> !tx_ready_r)
        else $error("probe withdrawal handed off a packet");

    a_done_irq: assert property (@(posedge ref_clk) disable iff (reset)
        eng_done && en_nxt[eng_done_pipe] |=>
            irq_r && (svc_pipe_r == $past(eng_done_pipe)))
        else $error("pipe done did not raise interrupt");

    a_read_order: assert property (@(posedge ref_clk) disable iff (reset)
        mcu_rd_pop |=> rd_data_r == $past(fifo_head[sel_idx]))
        else $error("data port read returned wrong byte");

endmodule

/* File: test/tb.sv */
// Self-checking bench for the endpoint FIFO access block.
// Assumes the engine model drives every engine-side input.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
    err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end end
module tb
    import uefa_pkg::*;
;
    logic             ref_clk   = 1'b0;
    logic             reset     = 1'b1;
    logic [7:0]       reg_addr  = 8'h00;
    logic [7:0]       reg_wdata = 8'h00;
    logic             reg_wr    = 1'b0;
    logic             reg_rd    = 1'b0;
    logic [7:0]       reg_rdata, eng_push_data, eng_pop_data;
    logic [1:0]       eng_busy;
    logic [CNT_W-1:0] eng_tx_len;
    logic             eng_push, eng_push_pipe, eng_pkt_end, eng_pkt_pipe;
    logic             eng_pkt_setup, eng_pkt_zero, eng_setup_token;
    logic             eng_pop, eng_pop_pipe, eng_done, eng_done_pipe;
    logic             eng_tx_ready, eng_tx_pipe, eng_rx_release;
    logic             eng_rx_pipe, irq;
    logic [7:0]       got [8];
    int               checks    = 0;
    int               err_count = 0;
    uefa_top dut (.*);
    uefa_eng_model m (.*);
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 `CHK("read", e, reg_rdata)
    endtask
    task automatic gap();
        repeat (200) @(posedge ref_clk);
    endtask
    task automatic results();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        results();
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        rd(8'h46, 8'h00);
        rd(8'h50, 8'h00);
        wr(8'h4C, 8'h02);
        m.rx(1'b0, 1'b1, 3, 8'hA0);
        #1 `CHK("irq", 1'b0, irq)
        rd(8'h4A, 8'h01);
        rd(8'h4D, 8'h00);
        wr(8'h4C, 8'h03);
        #1 `CHK("irq", 1'b1, irq)
        wr(8'h4B, 8'h01);
        #1 `CHK("irq", 1'b0, irq)
        rd(8'h4B, 8'h00);
        rd(8'h46, 8'h20);
        wr(8'h46, 8'h21);
        gap();
        rd(8'h46, 8'h61);
        for (int i = 0; i < 3; i++)
        begin
            gap();
            rd(8'h48, 8'hA0 + 8'(i));
        end
        rd(8'h46, 8'h21);
        wr(8'h46, 8'h23);
        #1 `CHK("rx_release", 2'b10, {eng_rx_release, eng_rx_pipe})
        wr(8'h46, 8'h02);
        rd(8'h46, 8'h02);
        wr(8'h46, 8'h0A);
        wr(8'h46, 8'h0B);
        gap();
        rd(8'h46, 8'h4B);
        for (int i = 0; i < 8; i++)
        begin
            gap();
            wr(8'h49, 8'h30 + 8'(i));
        end
        rd(8'h46, 8'h0B);
        wr(8'h46, 8'h09);
        #1 `CHK("tx", 6'h38, {eng_tx_ready, eng_tx_pipe, eng_tx_len})
        wr(8'h46, 8'h08);
        m.tx(1'b1, 8, got);
        for (int i = 0; i < 8; i++)
            `CHK("pop", 8'h30 + 8'(i), got[i])
        rd(8'h4D, 8'h01);
        wr(8'h4B, 8'h02);
        wr(8'h46, 8'h02);
        wr(8'h46, 8'h03);
        gap();
        rd(8'h46, 8'h43);
        wr(8'h46, 8'h01);
        #1 `CHK("tx", 6'h20, {eng_tx_ready, eng_tx_pipe, eng_tx_len})
        m.hold(1'b1, 1'b1);
        wr(8'h46, 8'h0A);
        wr(8'h46, 8'h0B);
        gap();
        rd(8'h46, 8'h0B);
        wr(8'h46, 8'h0A);
        #1 `CHK("tx_ready", 1'b0, eng_tx_ready)
        m.hold(1'b1, 1'b0);
        m.rx(1'b0, 1'b0, 2, 8'hC0);
        m.hold(1'b0, 1'b1);
        wr(8'h46, 8'h05);
        rd(8'h46, 8'h01);
        m.hold(1'b0, 1'b0);
        gap();
        rd(8'h46, 8'h01);
        wr(8'h46, 8'h00);
        m.rx(1'b1, 1'b0, 0, 8'h00);
        rd(8'h46, 8'h80);
        rd(8'h49, 8'h00);
        rd(8'h46, 8'h00);
        m.rx(1'b1, 1'b0, 0, 8'h00);
        m.tok();
        rd(8'h46, 8'h00);
        m.rx(1'b0, 1'b0, 1, 8'h55);
        wr(8'h46, 8'h11);
        gap();
        rd(8'h46, 8'h11);
        wr(8'h46, 8'h01);
        gap();
        rd(8'h46, 8'h41);
        rd(8'h48, 8'h55);
        results();
    end
endmodule

/* File: test/uefa_eng_model.sv */
// Engine-side model: moves packets into and out of the two pipes.
// Assumes one caller process; every strobe moves right after an edge.
`timescale 1ns/1ns
module uefa_eng_model
    import uefa_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Receive side
    output logic            eng_push,
    output logic            eng_push_pipe,
    output logic [7:0]      eng_push_data,
    output logic            eng_pkt_end,
    output logic            eng_pkt_pipe,
    output logic            eng_pkt_setup,
    output logic            eng_pkt_zero,
    output logic            eng_setup_token,
    // Transmit side
    output logic            eng_pop,
    output logic            eng_pop_pipe,
    input  wire logic [7:0] eng_pop_data,
    // Pipe ownership
    output logic [1:0]      eng_busy,
    output logic            eng_done,
    output logic            eng_done_pipe
);
    initial
    begin
        {eng_push, eng_push_pipe, eng_push_data, eng_pkt_end, eng_pkt_pipe,
         eng_pkt_setup, eng_pkt_zero, eng_setup_token, eng_pop,
         eng_pop_pipe, eng_busy, eng_done, eng_done_pipe} = '0;
    end
    task automatic hold(input logic p, input logic v);
        @(posedge ref_clk);
        eng_busy[p] <= v;
    endtask
    task automatic release_pipe(input logic p);
        @(posedge ref_clk);
        eng_pkt_end   <= 1'b0;
        eng_busy[p]   <= 1'b0;
        eng_done      <= 1'b1;
        eng_done_pipe <= p;
        @(posedge ref_clk);
        eng_done      <= 1'b0;
    endtask
    task automatic rx(input logic p, input logic su, input int n,
                      input logic [7:0] b);
        hold(p, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            eng_push      <= 1'b1;
            eng_push_pipe <= p;
            eng_push_data <= b + 8'(i);
        end
        @(posedge ref_clk);
        eng_push      <= 1'b0;
        eng_push_data <= ~eng_push_data;
        eng_pkt_end   <= 1'b1;
        eng_pkt_pipe  <= p;
        eng_pkt_setup <= su;
        eng_pkt_zero  <= (n == 0);
        release_pipe(p);
    endtask
    task automatic tx(input logic p, input int n, output logic [7:0] g [8]);
        hold(p, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            eng_pop      <= 1'b1;
            eng_pop_pipe <= p;
            @(posedge ref_clk);
            eng_pop      <= 1'b0;
            #1 g[i] = eng_pop_data;
        end
        release_pipe(p);
    endtask
    task automatic tok();
        @(posedge ref_clk);
        eng_setup_token <= 1'b1;
        @(posedge ref_clk);
        eng_setup_token <= 1'b0;
    endtask
endmodule
